// ### inc/mrw_pkg.sv
// package: constants and types of the mailbox memory read/write responder
package mrw_pkg;
    localparam int MB_COUNT = 32;
    localparam logic [4:0] CMD_CODE_RW = 5'h01;
    localparam int CMD_VERIFY_BIT = 1;
    localparam int CMD_READ_BIT = 0;
    localparam int STAT_DONE_BIT = 7;
    localparam int STAT_ERR_LSB = 4;
    localparam logic [7:0] MAX_WRITE_COUNT = 8'h1c;
    localparam logic [7:0] MAX_READ_COUNT = 8'h1e;
    localparam int PAYLOAD_FIRST_MB = 8;
    localparam int READ_DATA_FIRST_MB = 2;
    localparam int FAIL_HI_MB = 2;
    localparam int FAIL_LO_MB = 3;
    localparam int PAGE_SHIFT = 10;
    localparam int PAGE_COUNT = 32;
    localparam logic [2:0] SPACE_FLASH = 3'h0;
    localparam logic [2:0] SPACE_ROM = 3'h1;
    localparam logic [2:0] SPACE_RAM = 3'h2;
    localparam logic [2:0] SPACE_GPIO = 3'h3;
    localparam logic [2:0] SPACE_PERIPH8 = 3'h4;
    localparam logic [2:0] SPACE_PERIPH16 = 3'h5;
    localparam logic [7:0] BASE_FLASH = 8'h00;
    localparam logic [7:0] BASE_ROM = 8'h40;
    localparam logic [7:0] BASE_RAM = 8'h80;
    localparam logic [7:0] BASE_GPIO = 8'hc0;
    localparam logic [7:0] BASE_PERIPH8 = 8'hff;
    localparam logic [7:0] BASE_PERIPH16 = 8'hfe;
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_COUNT = 3'h1;
    localparam logic [2:0] ERR_SPACE = 3'h2;
    localparam logic [2:0] ERR_ACCESS = 3'h3;
    localparam logic [2:0] ERR_VERIFY = 3'h4;
    localparam logic [2:0] ERR_BUS = 3'h5;
    typedef enum logic [2:0] {
        MRW_IDLE, MRW_CHECK, MRW_ISSUE, MRW_WAIT, MRW_VERIFY, MRW_DONE
    } mrw_state_t;
endpackage

// ### inc/mrw_mem_if.sv
// interface: byte port from the command engine to the memory map
`timescale 1ns/1ps
interface mrw_mem_if;
    logic        req;
    logic        we;
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        ack;
    logic [7:0]  rdata;
    logic        err;
    modport engine (output req, output we, output addr, output wdata,
                     input ack, input rdata, input err);
    modport port   (input req, input we, input addr, input wdata,
                    output ack, output rdata, output err);
endinterface

// ### rtl/mrw_mem_port.sv
// module: registered bridge from the engine byte port to the memory pins
`timescale 1ns/1ps
module mrw_mem_port (
    // clock and reset
    input wire logic  mclk,
    input wire logic  rst,
    // engine side
    mrw_mem_if.port   eng,
    // memory pins
    output logic        mem_req,
    output logic        mem_we,
    output logic [23:0] mem_addr,
    output logic [7:0]  mem_wdata,
    input wire logic    mem_ack,
    input wire logic [7:0] mem_rdata,
    input wire logic    mem_err
);
    logic        busy;
    logic        next_busy;
    logic        next_req;
    logic        next_we;
    logic [23:0] next_addr;
    logic [7:0]  next_wdata;

    // one outstanding access; the engine holds req until ack
    always_comb begin
        next_busy  = busy;
        next_req   = mem_req;
        next_we    = mem_we;
        next_addr  = mem_addr;
        next_wdata = mem_wdata;
        if (!busy && eng.req) begin
            next_busy  = 1'b1;
            next_req   = 1'b1;
            next_we    = eng.we;
            next_addr  = eng.addr;
            next_wdata = eng.wdata;
        end else if (busy && mem_ack) begin
            next_busy = 1'b0;
            next_req  = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            busy      <= 1'b0;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 24'h000000;
            mem_wdata <= 8'h00;
        end else begin
            busy      <= next_busy;
            mem_req   <= next_req;
            mem_we    <= next_we;
            mem_addr  <= next_addr;
            mem_wdata <= next_wdata;
        end
    end

    assign eng.ack   = busy && mem_ack;
    assign eng.rdata = mem_rdata;
    assign eng.err   = mem_err;
endmodule

// ### rtl/mrw_responder.sv
// module: memory read/write command engine writing the response mailboxes
`timescale 1ns/1ps
module mrw_responder
    import mrw_pkg::*;
#(
    parameter logic [31:0] UNLOCK_KEY = 32'h5a5a_a5a5  // arbitrary value
) (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // command mailboxes, held stable by the host side until busy falls
    input wire logic       start,
    input wire logic [7:0] cmd_mb [MB_COUNT],
    // device state
    input wire logic       secure,
    input wire logic [PAGE_COUNT-1:0] page_protect_mask,
    // response mailboxes
    output logic [7:0]     rsp_mb [MB_COUNT],
    output logic           busy,
    // memory map pins
    output logic           mem_req,
    output logic           mem_we,
    output logic [23:0]    mem_addr,
    output logic [7:0]     mem_wdata,
    input wire logic       mem_ack,
    input wire logic [7:0] mem_rdata,
    input wire logic       mem_err
);
    mrw_mem_if mif();

    mrw_mem_port u_port (
        .mclk      (mclk),
        .rst       (rst),
        .eng       (mif.port),
        .mem_req   (mem_req),
        .mem_we    (mem_we),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_ack   (mem_ack),
        .mem_rdata (mem_rdata),
        .mem_err   (mem_err)
    );

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] space_base(input logic [2:0] sp);
        unique case (sp)
            SPACE_FLASH:    space_base = BASE_FLASH;
            SPACE_ROM:      space_base = BASE_ROM;
            SPACE_RAM:      space_base = BASE_RAM;
            SPACE_GPIO:     space_base = BASE_GPIO;
            SPACE_PERIPH8:  space_base = BASE_PERIPH8;
            default:        space_base = BASE_PERIPH16;
        endcase
    endfunction

    function automatic logic [7:0] status_byte(input logic done, input logic [2:0] e);
        status_byte = {done, e, 4'h0};
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    mrw_state_t  state, next_state;
    logic [7:0]  rsp [MB_COUNT];
    logic [7:0]  next_rsp [MB_COUNT];
    logic [7:0]  cmd, next_cmd;
    logic [2:0]  space, next_space;
    logic [4:0]  count, next_count;
    logic [4:0]  idx, next_idx;
    logic [15:0] addr, next_addr;
    logic [2:0]  err, next_err;
    logic        failed, next_failed;
    logic        vphase, next_vphase;

    logic        is_read;
    logic        do_verify;
    logic [31:0] key;
    logic        key_ok;
    logic [4:0]  page;
    logic [7:0]  wbyte;

    assign is_read   = cmd[CMD_READ_BIT];
    assign do_verify = cmd[CMD_VERIFY_BIT] && !is_read;
    assign key       = {cmd_mb[2], cmd_mb[3], cmd_mb[4], cmd_mb[5]};
    assign key_ok    = key == UNLOCK_KEY;
    assign page      = addr[PAGE_SHIFT +: 5];
    assign wbyte     = cmd_mb[PAYLOAD_FIRST_MB + int'(idx)];

    // request only from WAIT, so a byte refused in ISSUE never reaches the port
    assign mif.req   = state == MRW_WAIT;
    assign mif.we    = !is_read && !vphase;
    assign mif.addr  = {space_base(space), addr};
    assign mif.wdata = wbyte;
    assign rsp_mb    = rsp;
    assign busy      = state != MRW_IDLE;

    always_comb begin
        next_state  = state;
        next_rsp    = rsp;
        next_cmd    = cmd;
        next_space  = space;
        next_count  = count;
        next_idx    = idx;
        next_addr   = addr;
        next_err    = err;
        next_failed = failed;
        next_vphase = vphase;
        unique case (state)
            MRW_IDLE: begin
                if (start && cmd_mb[0][7:3] == CMD_CODE_RW) begin
                    next_cmd    = cmd_mb[0];
                    next_space  = cmd_mb[1][7:5];
                    next_count  = cmd_mb[1][4:0];
                    next_addr   = {cmd_mb[6], cmd_mb[7]};
                    next_idx    = 5'h00;
                    next_err    = ERR_NONE;
                    next_failed = 1'b0;
                    next_vphase = 1'b0;
                    next_rsp[0] = cmd_mb[0];
                    next_rsp[1] = status_byte(1'b0, ERR_NONE);
                    next_state  = MRW_CHECK;
                end
            end
            MRW_CHECK: begin
                next_state = MRW_ISSUE;
                // a five-bit field can still exceed the write limit
                if (is_read ? (8'(count) > MAX_READ_COUNT)
                            : (8'(count) > MAX_WRITE_COUNT)) begin
                    next_err = ERR_COUNT;
                end else if (space > SPACE_PERIPH16) begin
                    next_err = ERR_SPACE;
                end else if (secure) begin
                    next_err = ERR_ACCESS;
                end else if ((space == SPACE_ROM && (!is_read || !key_ok)) ||
                             (space == SPACE_PERIPH16 && !key_ok)) begin
                    next_err = ERR_ACCESS;
                end
                if (count == 5'h00 || next_err != ERR_NONE) begin
                    next_state = MRW_DONE;
                end
            end
            MRW_ISSUE: begin
                // each flash byte written is checked against its own page
                if (space == SPACE_FLASH && !is_read && !page_protect_mask[page]) begin
                    next_err   = ERR_ACCESS;
                    next_state = MRW_DONE;
                end else begin
                    next_state = MRW_WAIT;
                end
            end
            MRW_WAIT: begin
                if (mif.ack) begin
                    if (mif.err) begin
                        next_err   = ERR_BUS;
                        next_state = MRW_DONE;
                    end else if (is_read) begin
                        next_rsp[READ_DATA_FIRST_MB + int'(idx)] = mif.rdata;
                        next_state = MRW_VERIFY;
                    end else if (do_verify && !vphase) begin
                        next_vphase = 1'b1;
                        next_state  = MRW_ISSUE;
                    end else begin
                        if (vphase && mif.rdata != wbyte && !failed) begin
                            next_failed = 1'b1;
                            next_err    = ERR_VERIFY;
                            next_rsp[FAIL_HI_MB] = addr[15:8];
                            next_rsp[FAIL_LO_MB] = addr[7:0];
                        end
                        next_vphase = 1'b0;
                        next_state  = MRW_VERIFY;
                    end
                end
            end
            MRW_VERIFY: begin
                next_idx  = idx + 5'h01;
                next_addr = addr + 16'h0001;
                next_state = (idx + 5'h01 == count) ? MRW_DONE : MRW_ISSUE;
            end
            MRW_DONE: begin
                next_rsp[1] = status_byte(1'b1, err);
                next_state  = MRW_IDLE;
            end
            default: next_state = MRW_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state  <= MRW_IDLE;
            rsp    <= '{default: 8'h00};
            cmd    <= 8'h00;
            space  <= 3'h0;
            count  <= 5'h00;
            idx    <= 5'h00;
            addr   <= 16'h0000;
            err    <= 3'h0;
            failed <= 1'b0;
            vphase <= 1'b0;
        end else begin
            state  <= next_state;
            rsp    <= next_rsp;
            cmd    <= next_cmd;
            space  <= next_space;
            count  <= next_count;
            idx    <= next_idx;
            addr   <= next_addr;
            err    <= next_err;
            failed <= next_failed;
            vphase <= next_vphase;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    echo_cmd_a: assert property (@(posedge mclk) disable iff (rst)
        (state == MRW_IDLE && start && cmd_mb[0][7:3] == CMD_CODE_RW)
        |=> rsp[0] == $past(cmd_mb[0]))
        else $error("command byte not echoed");
    status_low_a: assert property (@(posedge mclk) disable iff (rst)
        rsp[1][3:0] == 4'h0)
        else $error("status low nibble not zero");
    done_low_a: assert property (@(posedge mclk) disable iff (rst)
        (state inside {MRW_CHECK, MRW_ISSUE, MRW_WAIT, MRW_VERIFY}) |-> !rsp[1][STAT_DONE_BIT])
        else $error("done flag set while busy");
    done_set_a: assert property (@(posedge mclk) disable iff (rst)
        state == MRW_DONE |=> rsp[1][STAT_DONE_BIT] && rsp[1][6:4] == $past(err))
        else $error("done flag or error not reported");
    secure_deny_a: assert property (@(posedge mclk) disable iff (rst)
        (state == MRW_CHECK && secure && count != 5'h00) |=> !mif.req ##1 rsp[1][6:4] != ERR_NONE)
        else $error("secured access not refused");
    count_limit_a: assert property (@(posedge mclk) disable iff (rst)
        (state == MRW_CHECK && !is_read && 8'(count) > MAX_WRITE_COUNT)
        |=> state == MRW_DONE && err == ERR_COUNT)
        else $error("write count over limit accepted");
    rom_write_a: assert property (@(posedge mclk) disable iff (rst)
        (mif.req && mif.we) |-> space != SPACE_ROM)
        else $error("rom write issued");
    flash_mask_a: assert property (@(posedge mclk) disable iff (rst)
        (mem_req && mem_we && mem_addr[23:16] == BASE_FLASH)
        |-> page_protect_mask[mem_addr[PAGE_SHIFT +: 5]])
        else $error("protected flash page written");
    read_place_a: assert property (@(posedge mclk) disable iff (rst)
        (state == MRW_WAIT && mif.ack && !mif.err && is_read)
        |=> rsp[READ_DATA_FIRST_MB + int'($past(idx))] == $past(mif.rdata))
        else $error("read byte misplaced");
endmodule

// ### verif/mrw_mem_model.sv
// partner model: memory map answering the responder byte requests
`timescale 1ns/1ps
module mrw_mem_model (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // memory pins
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    output logic            mem_ack,
    output logic [7:0]      mem_rdata,
    output logic            mem_err,
    // pacing and faults set by the bench
    input wire logic [3:0]  lag,
    input wire logic [23:0] bad_addr,
    input wire logic [23:0] fault_addr,
    output int              n_access
);
    logic [7:0] mem [logic [23:0]];
    logic [7:0] last = 8'h00;
    int         gap = 0;
    int         cnt = 0;
    // unwritten places read as the top address byte xor the low address byte, so the top byte shows
    function automatic logic [7:0] peek(input logic [23:0] a);
        return mem.exists(a) ? mem[a] : a[23:16] ^ a[7:0];
    endfunction
    // read data outside an answer never repeats the last byte read
    always @(posedge mclk) begin
        mem_ack <= 1'b0;
        mem_err <= 1'b0;
        mem_rdata <= ~last;
        if (rst) begin
            cnt = 0;
            gap = 0;
        end else if (gap > 0) begin
            // the request may linger while the answer travels back
            gap--;
        end else if (mem_req === 1'b1) begin
            if (cnt < int'(lag)) begin
                cnt++;
            end else begin
                cnt = 0;
                gap = 2;
                n_access++;
                mem_ack <= 1'b1;
                if (mem_addr == fault_addr) begin
                    mem_err <= 1'b1;
                end else if (mem_we) begin
                    mem[mem_addr] = (mem_addr == bad_addr) ? ~mem_wdata : mem_wdata;
                end else begin
                    last = peek(mem_addr);
                    mem_rdata <= last;
                end
            end
        end
    end
endmodule

// ### verif/mrw_responder_bench.sv
// testbench of the mailbox memory read/write responder
`timescale 1ns/1ps
module mrw_responder_bench;
    import mrw_pkg::*;
    localparam logic [31:0] KEY = 32'h5a5a_a5a5;  // arbitrary value
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic        secure = 1'b0;
    logic [31:0] page_protect_mask = 32'h0;
    logic [7:0]  cmd_mb [MB_COUNT];
    logic [7:0]  rsp_mb [MB_COUNT];
    logic        busy, mem_req, mem_we, mem_ack, mem_err;
    logic [23:0] mem_addr;
    logic [7:0]  mem_wdata, mem_rdata, exp_b;
    logic [3:0]  lag = 4'h0;
    logic [23:0] bad_addr = 24'hffffff;
    logic [23:0] fault_addr = 24'hffffff;
    logic [7:0]  wd [24];
    logic [7:0]  bases [6] = '{BASE_FLASH, BASE_ROM, BASE_RAM, BASE_GPIO,
                               BASE_PERIPH8, BASE_PERIPH16};
    int          n_access, base;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    mrw_responder #(.UNLOCK_KEY(KEY)) i_dut (.mclk(mclk), .rst(rst), .start(start),
        .cmd_mb(cmd_mb), .secure(secure), .page_protect_mask(page_protect_mask),
        .rsp_mb(rsp_mb), .busy(busy), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .mem_err(mem_err));
    mrw_mem_model i_mem (.mclk(mclk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .mem_err(mem_err), .lag(lag), .bad_addr(bad_addr),
        .fault_addr(fault_addr), .n_access(n_access));
    always #20 mclk = ~mclk;
    // ----------------------------------------
    // checking and command tasks
    // ----------------------------------------
    task automatic finish_test();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // mailboxes stay put until busy falls, as the host would leave them
    task automatic run(input logic [7:0] cmd, input logic [7:0] par, input logic [15:0] addr,
                       input logic [31:0] pw, input logic [7:0] stat);
        @(posedge mclk);
        #1;
        cmd_mb[0] = cmd;
        cmd_mb[1] = par;
        {cmd_mb[2], cmd_mb[3], cmd_mb[4], cmd_mb[5], cmd_mb[6], cmd_mb[7]} = {pw, addr};
        for (int i = 0; i < 24; i++) cmd_mb[8 + i] = wd[i];
        start = 1'b1;
        @(posedge mclk);
        #1;
        start = 1'b0;
        for (int i = 0; i < 600 && busy !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
            if (busy === 1'b1) cmp(rsp_mb[1] & 8'h80, 8'h00);
        end
        cmp(rsp_mb[0], cmd);
        cmp(rsp_mb[1], stat);
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            $display("ERROR %0t: timeout", $time);
            finish_test();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        for (int i = 0; i < MB_COUNT; i++) cmd_mb[i] = 8'h00;
        for (int i = 0; i < 24; i++) wd[i] = 8'(i * 37 + 5);
        repeat (10) @(posedge mclk);
        #1;
        rst = 1'b0;
        run(8'h08, {SPACE_RAM, 5'd4}, 16'h0010, 32'h0, 8'h80);
        run(8'h0b, {SPACE_RAM, 5'd4}, 16'h0010, 32'h0, 8'h80);
        for (int i = 0; i < 4; i++) cmp(rsp_mb[2 + i], wd[i]);
        run(8'h09, {SPACE_RAM, 5'd30}, 16'h0100, 32'h0, 8'h80);
        for (int i = 0; i < 30; i++) cmp(rsp_mb[2 + i], 8'h80 ^ 8'(i));
        run(8'h09, {SPACE_RAM, 5'd31}, 16'h0100, 32'h0, 8'h90);
        run(8'h08, {SPACE_RAM, 5'd29}, 16'h0100, 32'h0, 8'h90);
        base = n_access;
        run(8'h08, {SPACE_RAM, 5'd0}, 16'h0100, 32'h0, 8'h80);
        cmp(8'(n_access - base), 8'h00);
        run(8'h09, {3'h6, 5'd1}, 16'h0100, 32'h0, 8'ha0);
        for (int s = 0; s < 6; s++) begin
            for (int p = 0; p < 2; p++) begin
                exp_b = (p == 0 && (s == 1 || s == 5)) ? 8'hb0 : 8'h80;
                run(8'h09, {3'(s), 5'd1}, 16'h0044, p ? KEY : 32'h0, exp_b);
                if (exp_b == 8'h80) cmp(rsp_mb[2], bases[s] ^ 8'h44);
            end
        end
        secure = 1'b1;
        for (int s = 0; s < 6; s++) run(8'h09, {3'(s), 5'd1}, 16'h0044, KEY, 8'hb0);
        run(8'h08, {SPACE_RAM, 5'd4}, 16'h0010, KEY, 8'hb0);
        secure = 1'b0;
        run(8'h08, {SPACE_ROM, 5'd4}, 16'h0010, KEY, 8'hb0);
        // flash writes are refused unless the page's page_protect_mask bit is set
        base = n_access;
        run(8'h08, {SPACE_FLASH, 5'd4}, 16'h0c00, 32'h0, 8'hb0);
        cmp(8'(n_access - base), 8'h00);
        page_protect_mask = 32'h0000_0008;
        run(8'h08, {SPACE_FLASH, 5'd8}, 16'h0c00, 32'h0, 8'h80);
        cmp(8'(n_access - base), 8'h08);
        lag = 4'h5;
        bad_addr = 24'h800206;
        run(8'h0a, {SPACE_RAM, 5'd4}, 16'h0204, 32'h0, 8'hc0);
        cmp(rsp_mb[2], 8'h02);
        cmp(rsp_mb[3], 8'h06);
        run(8'h08, {SPACE_RAM, 5'd4}, 16'h0204, 32'h0, 8'h80);
        fault_addr = 24'h800301;
        run(8'h09, {SPACE_RAM, 5'd4}, 16'h0300, 32'h0, 8'hd0);
        @(posedge mclk);
        #1;
        cmd_mb[0] = 8'h10;
        start = 1'b1;
        @(posedge mclk);
        #1;
        start = 1'b0;
        cmp({7'h0, busy}, 8'h00);
        cmp(rsp_mb[1], 8'hd0);
        finish_test();
    end
endmodule
